// ---- common/vfem_pkg.sv ----
package vfem_pkg;

	localparam int VFEM_CLASS_W = 6;
	localparam int VFEM_ADDR_W = 12;
	localparam int VFEM_DATA_W = 32;
	localparam int VFEM_COUNT_W = 16;
	localparam int VFEM_LOOKUP_LAT = 2;

	typedef enum logic [5:0] {
		OP_SP_STORE_CONTROL_STATUS = 6'h00,
		OP_SP_PACKED_SUB = 6'h01,
		OP_SP_SCALAR_SUB = 6'h02,
		OP_SP_UNORDERED_COMPARE_FLAGS = 6'h03,
		OP_SP_HIGH_INTERLEAVE = 6'h04,
		OP_SP_LOW_INTERLEAVE = 6'h05,
		OP_SP_PACKED_XOR = 6'h06,
		OP_DP_PACKED_ADD = 6'h07,
		OP_DP_SCALAR_ADD = 6'h08,
		OP_DP_INVERTED_AND = 6'h09,
		OP_DP_BITWISE_AND = 6'h0A,
		OP_DP_PACKED_PREDICATE_COMPARE = 6'h0B,
		OP_DP_SCALAR_PREDICATE_COMPARE = 6'h0C,
		OP_DP_ORDERED_COMPARE_FLAGS = 6'h0D,
		OP_INT_LANES_TO_SP = 6'h0E,
		OP_SP_TO_INT_LANES_ROUNDED = 6'h0F,
		OP_SP_TO_INT_LANES_TRUNCATED = 6'h10,
		OP_INT_LANES_TO_DP = 6'h11,
		OP_DP_TO_INT_LANES_ROUNDED = 6'h12,
		OP_DP_TO_INT_PAIR_ROUNDED = 6'h13,
		OP_DP_PACKED_NARROW_TO_SP = 6'h14,
		OP_LEGACY_INT_PAIR_TO_DP = 6'h15,
		OP_SP_PACKED_WIDEN_TO_DP = 6'h16,
		OP_DP_SCALAR_TO_GPR_INT_ROUNDED = 6'h17,
		OP_DP_SCALAR_NARROW_TO_SP = 6'h18,
		OP_GPR_INT_TO_DP_SCALAR = 6'h19,
		OP_SP_SCALAR_WIDEN_TO_DP = 6'h1A,
		OP_DP_TO_INT_LANES_TRUNCATED = 6'h1B,
		OP_DP_TO_INT_PAIR_TRUNCATED = 6'h1C,
		OP_DP_SCALAR_TO_GPR_INT_TRUNCATED = 6'h1D,
		OP_DP_PACKED_DIVIDE = 6'h1E,
		OP_DP_SCALAR_DIVIDE = 6'h1F,
		OP_DP_PACKED_MAXIMUM = 6'h20,
		OP_DP_SCALAR_MAXIMUM = 6'h21,
		OP_DP_PACKED_MINIMUM = 6'h22,
		OP_DP_SCALAR_MINIMUM = 6'h23,
		OP_DP_ALIGNED_MOVE = 6'h24,
		OP_DP_HIGH_HALF_MOVE = 6'h25,
		OP_DP_LOW_HALF_MOVE = 6'h26,
		OP_DP_SIGN_MASK_EXTRACT = 6'h27,
		OP_DP_SCALAR_MOVE = 6'h28,
		OP_DP_UNALIGNED_MOVE = 6'h29,
		OP_DP_PACKED_MULTIPLY = 6'h2A
	} vfem_class_t;

	// msb first: invalid, denormal, divide by zero, overflow, underflow, precision
	typedef struct packed {
		logic inv;
		logic den;
		logic zdiv;
		logic ovf;
		logic unf;
		logic prec;
	} vfem_cap_t;

	localparam vfem_cap_t VFEM_CAP_NONE = 6'h00;
	localparam vfem_cap_t VFEM_CAP_ID = 6'h30;
	localparam vfem_cap_t VFEM_CAP_IP = 6'h21;
	localparam vfem_cap_t VFEM_CAP_P = 6'h01;
	localparam vfem_cap_t VFEM_CAP_ALL = 6'h3F;
	localparam vfem_cap_t VFEM_CAP_NO_Z = 6'h37;
	localparam vfem_cap_t VFEM_CAP_DOUP = 6'h17;

	typedef struct packed {
		logic valid;
		logic [VFEM_CLASS_W-1:0] cls;
		vfem_cap_t raised;
	} vfem_look_req_t;

	typedef struct packed {
		logic valid;
		logic known;
		vfem_cap_t cap;
		vfem_cap_t permitted;
		logic denied;
	} vfem_look_rsp_t;

	typedef enum logic [1:0] {
		VFEM_ST_IDLE = 2'h1,
		VFEM_ST_RESP = 2'h2
	} vfem_apb_st_t;

	localparam logic [VFEM_ADDR_W-1:0] VFEM_CTRL_OFF = 12'h000;
	localparam logic [VFEM_ADDR_W-1:0] VFEM_STATUS_OFF = 12'h004;
	localparam logic [VFEM_ADDR_W-1:0] VFEM_QUERY_OFF = 12'h008;
	localparam logic [VFEM_ADDR_W-1:0] VFEM_VCOUNT_OFF = 12'h00C;

	localparam int VFEM_CTRL_EN_BIT = 0;
	localparam logic VFEM_CTRL_EN_RST = 1'h1;
	localparam int VFEM_STAT_VIOL_BIT = 0;
	localparam int VFEM_STAT_CLS_LSB = 8;
	localparam int VFEM_QUERY_CLS_LSB = 0;
	localparam int VFEM_QUERY_CAP_LSB = 16;
	localparam int VFEM_QUERY_UNK_BIT = 31;

endpackage

// ---- rtl/vfem_cap_rom.sv ----
module vfem_cap_rom (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [vfem_pkg::VFEM_CLASS_W-1:0] cls,
	output vfem_pkg::vfem_cap_t cap,
	output logic known
);
	import vfem_pkg::*;

	vfem_cap_t cap_reg, cap_next;
	logic known_reg, known_next;

	always_comb begin
		known_next = 1'b1;
		case (vfem_class_t'(cls))
			OP_SP_STORE_CONTROL_STATUS, OP_SP_PACKED_XOR: cap_next = VFEM_CAP_NONE;
			OP_SP_HIGH_INTERLEAVE, OP_SP_LOW_INTERLEAVE: cap_next = VFEM_CAP_NONE;
			OP_SP_PACKED_SUB, OP_SP_SCALAR_SUB: cap_next = VFEM_CAP_DOUP;
			OP_SP_UNORDERED_COMPARE_FLAGS: cap_next = VFEM_CAP_ID;
			OP_DP_PACKED_ADD, OP_DP_SCALAR_ADD: cap_next = VFEM_CAP_NO_Z;
			OP_DP_INVERTED_AND, OP_DP_BITWISE_AND: cap_next = VFEM_CAP_NONE;
			OP_DP_PACKED_PREDICATE_COMPARE, OP_DP_SCALAR_PREDICATE_COMPARE,
			OP_DP_ORDERED_COMPARE_FLAGS: cap_next = VFEM_CAP_ID;
			OP_INT_LANES_TO_SP: cap_next = VFEM_CAP_P;
			OP_SP_TO_INT_LANES_ROUNDED, OP_SP_TO_INT_LANES_TRUNCATED: cap_next = VFEM_CAP_IP;
			OP_DP_TO_INT_LANES_ROUNDED, OP_DP_TO_INT_PAIR_ROUNDED, OP_DP_SCALAR_TO_GPR_INT_ROUNDED,
			OP_DP_TO_INT_LANES_TRUNCATED, OP_DP_TO_INT_PAIR_TRUNCATED,
			OP_DP_SCALAR_TO_GPR_INT_TRUNCATED: cap_next = VFEM_CAP_IP;
			OP_INT_LANES_TO_DP, OP_LEGACY_INT_PAIR_TO_DP,
			OP_GPR_INT_TO_DP_SCALAR: cap_next = VFEM_CAP_NONE;
			OP_DP_PACKED_NARROW_TO_SP, OP_DP_SCALAR_NARROW_TO_SP: cap_next = VFEM_CAP_NO_Z;
			OP_SP_PACKED_WIDEN_TO_DP, OP_SP_SCALAR_WIDEN_TO_DP: cap_next = VFEM_CAP_ID;
			OP_DP_PACKED_DIVIDE, OP_DP_SCALAR_DIVIDE: cap_next = VFEM_CAP_ALL;
			OP_DP_PACKED_MAXIMUM, OP_DP_SCALAR_MAXIMUM,
			OP_DP_PACKED_MINIMUM, OP_DP_SCALAR_MINIMUM: cap_next = VFEM_CAP_ID;
			OP_DP_ALIGNED_MOVE, OP_DP_HIGH_HALF_MOVE, OP_DP_LOW_HALF_MOVE,
			OP_DP_SCALAR_MOVE, OP_DP_UNALIGNED_MOVE: cap_next = VFEM_CAP_NONE;
			OP_DP_SIGN_MASK_EXTRACT: cap_next = VFEM_CAP_NONE;
			OP_DP_PACKED_MULTIPLY: cap_next = VFEM_CAP_NO_Z;
			default: begin
				// unknown codes allow nothing, so a bad decode cannot leak a flag
				cap_next = VFEM_CAP_NONE;
				known_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cap_reg <= VFEM_CAP_NONE;
			known_reg <= 1'b0;
		end else begin
			cap_reg <= cap_next;
			known_reg <= known_next;
		end
	end

	assign cap = cap_reg;
	assign known = known_reg;

endmodule

// ---- rtl/vfem_top.sv ----
module vfem_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [vfem_pkg::VFEM_ADDR_W-1:0] paddr,
	input wire logic [vfem_pkg::VFEM_DATA_W-1:0] pwdata,
	output logic [vfem_pkg::VFEM_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input vfem_pkg::vfem_look_req_t look_req,
	output vfem_pkg::vfem_look_rsp_t look_rsp
);
	import vfem_pkg::*;

	// pipeline stage one: the table lookup itself
	vfem_cap_t pipe_cap;
	logic pipe_known;
	logic s1_valid_reg, s1_valid_next;
	vfem_cap_t s1_raised_reg, s1_raised_next;
	logic [VFEM_CLASS_W-1:0] s1_cls_reg, s1_cls_next;

	vfem_cap_rom u_pipe_rom (
		.clk(clk),
		.rst_n(rst_n),
		.cls(look_req.cls),
		.cap(pipe_cap),
		.known(pipe_known)
	);

	// software query port uses its own copy so it never stalls the pipeline
	vfem_cap_t query_cap;
	logic query_known;
	logic [VFEM_CLASS_W-1:0] query_cls_reg, query_cls_next;

	vfem_cap_rom u_query_rom (
		.clk(clk),
		.rst_n(rst_n),
		.cls(query_cls_reg),
		.cap(query_cap),
		.known(query_known)
	);

	logic ctrl_en_reg, ctrl_en_next;

	always_comb begin
		s1_valid_next = look_req.valid && ctrl_en_reg;
		s1_raised_next = look_req.raised;
		s1_cls_next = look_req.cls;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_valid_reg <= 1'b0;
			s1_raised_reg <= VFEM_CAP_NONE;
			s1_cls_reg <= '0;
		end else begin
			s1_valid_reg <= s1_valid_next;
			s1_raised_reg <= s1_raised_next;
			s1_cls_reg <= s1_cls_next;
		end
	end

	// stage two: filter raised flags against capability
	vfem_look_rsp_t rsp_reg, rsp_next;
	logic [VFEM_CLASS_W-1:0] rsp_cls_reg, rsp_cls_next;

	always_comb begin
		rsp_next.valid = s1_valid_reg;
		rsp_next.known = s1_valid_reg && pipe_known;
		rsp_next.cap = s1_valid_reg ? pipe_cap : VFEM_CAP_NONE;
		rsp_next.permitted = s1_valid_reg ? (s1_raised_reg & pipe_cap) : VFEM_CAP_NONE;
		rsp_next.denied = s1_valid_reg && ((s1_raised_reg & ~pipe_cap) != VFEM_CAP_NONE);
		rsp_cls_next = s1_cls_reg;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rsp_reg <= '0;
			rsp_cls_reg <= '0;
		end else begin
			rsp_reg <= rsp_next;
			rsp_cls_reg <= rsp_cls_next;
		end
	end

	assign look_rsp = rsp_reg;

	// apb slave and register file
	vfem_apb_st_t st_reg, st_next;
	logic [VFEM_DATA_W-1:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic viol_reg, viol_next;
	logic [VFEM_CLASS_W-1:0] viol_cls_reg, viol_cls_next;
	logic [VFEM_COUNT_W-1:0] vcount_reg, vcount_next;
	logic addr_hit;
	logic wr_commit;

	always_comb begin
		addr_hit = (paddr == VFEM_CTRL_OFF) || (paddr == VFEM_STATUS_OFF) ||
			(paddr == VFEM_QUERY_OFF) || (paddr == VFEM_VCOUNT_OFF);
		// writes land at the edge where the master sees pready high
		wr_commit = (st_reg == VFEM_ST_RESP) && psel && penable && pwrite && addr_hit;
	end

	always_comb begin
		st_next = st_reg;
		prdata_next = prdata_reg;
		pready_next = 1'b0;
		pslverr_next = 1'b0;
		case (st_reg)
			VFEM_ST_IDLE: begin
				if (psel && penable) begin
					st_next = VFEM_ST_RESP;
					pready_next = 1'b1;
					pslverr_next = !addr_hit;
					prdata_next = '0;
					if (!pwrite) begin
						case (paddr)
							VFEM_CTRL_OFF: prdata_next[VFEM_CTRL_EN_BIT] = ctrl_en_reg;
							VFEM_STATUS_OFF: begin
								prdata_next[VFEM_STAT_VIOL_BIT] = viol_reg;
								prdata_next[VFEM_STAT_CLS_LSB +: VFEM_CLASS_W] = viol_cls_reg;
							end
							VFEM_QUERY_OFF: begin
								prdata_next[VFEM_QUERY_CLS_LSB +: VFEM_CLASS_W] = query_cls_reg;
								prdata_next[VFEM_QUERY_CAP_LSB +: $bits(vfem_cap_t)] = query_cap;
								prdata_next[VFEM_QUERY_UNK_BIT] = !query_known;
							end
							VFEM_VCOUNT_OFF: prdata_next[VFEM_COUNT_W-1:0] = vcount_reg;
							default: prdata_next = '0;
						endcase
					end
				end
			end
			VFEM_ST_RESP: begin
				st_next = VFEM_ST_IDLE;
				prdata_next = '0;
			end
			default: begin
				st_next = VFEM_ST_IDLE;
				prdata_next = '0;
			end
		endcase
	end

	always_comb begin
		ctrl_en_next = ctrl_en_reg;
		query_cls_next = query_cls_reg;
		viol_next = viol_reg;
		viol_cls_next = viol_cls_reg;
		vcount_next = vcount_reg;
		if (wr_commit && paddr == VFEM_CTRL_OFF)
			ctrl_en_next = pwdata[VFEM_CTRL_EN_BIT];
		if (wr_commit && paddr == VFEM_QUERY_OFF)
			query_cls_next = pwdata[VFEM_QUERY_CLS_LSB +: VFEM_CLASS_W];
		if (wr_commit && paddr == VFEM_STATUS_OFF && pwdata[VFEM_STAT_VIOL_BIT])
			viol_next = 1'b0;
		// a violation in the clearing cycle still sets the flag
		if (rsp_reg.denied) begin
			viol_next = 1'b1;
			viol_cls_next = rsp_cls_reg;
			if (vcount_reg != '1)
				vcount_next = vcount_reg + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_reg <= VFEM_ST_IDLE;
			prdata_reg <= '0;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			ctrl_en_reg <= VFEM_CTRL_EN_RST;
			query_cls_reg <= '0;
			viol_reg <= 1'b0;
			viol_cls_reg <= '0;
			vcount_reg <= '0;
		end else begin
			st_reg <= st_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			ctrl_en_reg <= ctrl_en_next;
			query_cls_reg <= query_cls_next;
			viol_reg <= viol_next;
			viol_cls_reg <= viol_cls_next;
			vcount_reg <= vcount_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_issue(logic [VFEM_CLASS_W-1:0] c);
		look_req.valid && ctrl_en_reg && look_req.cls == c;
	endsequence

	sequence s_answer(vfem_cap_t v);
		##VFEM_LOOKUP_LAT (look_rsp.valid && look_rsp.cap == v);
	endsequence

	property p_subset;
		look_rsp.valid |-> ((look_rsp.permitted & ~look_rsp.cap) == VFEM_CAP_NONE) &&
			(look_rsp.denied == ((look_rsp.permitted != $past(s1_raised_reg)) ? 1'b1 : 1'b0));
	endproperty
	a_subset: assert property (p_subset) else $error("flag passed outside capability");

	property p_logic_none;
		s_issue(OP_DP_INVERTED_AND) or s_issue(OP_DP_BITWISE_AND) |-> s_answer(VFEM_CAP_NONE);
	endproperty
	a_logic_none: assert property (p_logic_none) else $error("bitwise and given a capability");

	property p_sp_ucmp;
		s_issue(OP_SP_UNORDERED_COMPARE_FLAGS) |-> s_answer(VFEM_CAP_ID);
	endproperty
	a_sp_ucmp: assert property (p_sp_ucmp) else $error("sp unordered compare map wrong");

	property p_dp_add;
		s_issue(OP_DP_PACKED_ADD) or s_issue(OP_DP_SCALAR_ADD) |-> s_answer(VFEM_CAP_NO_Z);
	endproperty
	a_dp_add: assert property (p_dp_add) else $error("dp add map wrong");

	property p_dp_cmp;
		s_issue(OP_DP_PACKED_PREDICATE_COMPARE) or s_issue(OP_DP_SCALAR_PREDICATE_COMPARE) or
			s_issue(OP_DP_ORDERED_COMPARE_FLAGS) |-> s_answer(VFEM_CAP_ID);
	endproperty
	a_dp_cmp: assert property (p_dp_cmp) else $error("dp compare map wrong");

	property p_int_sp;
		s_issue(OP_INT_LANES_TO_SP) |-> s_answer(VFEM_CAP_P);
	endproperty
	a_int_sp: assert property (p_int_sp) else $error("int to sp map wrong");

	property p_sp_int;
		s_issue(OP_SP_TO_INT_LANES_TRUNCATED) |-> s_answer(VFEM_CAP_IP);
	endproperty
	a_sp_int: assert property (p_sp_int) else $error("sp to int map wrong");

	property p_dp_div;
		s_issue(OP_DP_PACKED_DIVIDE) or s_issue(OP_DP_SCALAR_DIVIDE) |-> s_answer(VFEM_CAP_ALL);
	endproperty
	a_dp_div: assert property (p_dp_div) else $error("dp divide lacks divide by zero");

	property p_move_none;
		s_issue(OP_DP_UNALIGNED_MOVE) |-> s_answer(VFEM_CAP_NONE);
	endproperty
	a_move_none: assert property (p_move_none) else $error("dp move given a capability");

	property p_off_quiet;
		!ctrl_en_reg && !$past(ctrl_en_reg) |-> ##1 !look_rsp.valid;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("lookup answered while disabled");

	property p_viol_sticky;
		look_rsp.denied |=> viol_reg [*2] or (viol_reg ##1 !viol_reg && $past(wr_commit));
	endproperty
	a_viol_sticky: assert property (p_viol_sticky) else $error("violation flag lost");

	property p_apb_one_wait;
		psel && penable && !pready |=> pready ##1 !pready;
	endproperty
	a_apb_one_wait: assert property (p_apb_one_wait) else $error("apb answer timing wrong");

endmodule

// ---- tb/tb.sv ----
`define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
	$display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import vfem_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [VFEM_ADDR_W-1:0] paddr = '0;
	logic [VFEM_DATA_W-1:0] pwdata = '0;
	logic [VFEM_DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	vfem_look_req_t look_req = '0;
	vfem_look_rsp_t look_rsp;
	vfem_look_rsp_t s1 = '0;
	vfem_look_rsp_t s2 = '0;
	logic [5:0] c1 = '0;
	logic [5:0] c2 = '0;
	logic en_exp = 1'b1;
	int exp_vcnt = 0;
	logic [5:0] exp_cls = '0;
	int error_cnt = 0;
	int num_checks = 0;

	vfem_top vfem_top_i (
		.clk(clk),
		.rst_n(rst_n),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.look_req(look_req),
		.look_rsp(look_rsp)
	);

	always #2.5 clk = ~clk;

	// known bit on top, capability set below
	function automatic logic [6:0] cap_of(input logic [5:0] c);
		case (c)
			6'h00, 6'h06: return {1'b1, VFEM_CAP_NONE};
			6'h01, 6'h02: return {1'b1, VFEM_CAP_DOUP};
			6'h03: return {1'b1, VFEM_CAP_ID};
			6'h04, 6'h05, 6'h27: return {1'b1, VFEM_CAP_NONE};
			6'h07, 6'h08: return {1'b1, VFEM_CAP_NO_Z};
			6'h09, 6'h0A: return {1'b1, VFEM_CAP_NONE};
			6'h0B, 6'h0C, 6'h0D: return {1'b1, VFEM_CAP_ID};
			6'h0E: return {1'b1, VFEM_CAP_P};
			6'h0F, 6'h10: return {1'b1, VFEM_CAP_IP};
			6'h11, 6'h15, 6'h19: return {1'b1, VFEM_CAP_NONE};
			6'h12, 6'h13, 6'h17, 6'h1B, 6'h1C, 6'h1D: return {1'b1, VFEM_CAP_IP};
			6'h14, 6'h18: return {1'b1, VFEM_CAP_NO_Z};
			6'h16, 6'h1A: return {1'b1, VFEM_CAP_ID};
			6'h1E, 6'h1F: return {1'b1, VFEM_CAP_ALL};
			6'h20, 6'h21, 6'h22, 6'h23: return {1'b1, VFEM_CAP_ID};
			6'h24, 6'h25, 6'h26, 6'h28, 6'h29: return {1'b1, VFEM_CAP_NONE};
			6'h2A: return {1'b1, VFEM_CAP_NO_Z};
			default: return 7'h00;
		endcase
	endfunction

	function automatic vfem_look_rsp_t exp_rsp(input vfem_look_req_t r, input logic en);
		vfem_look_rsp_t e;
		logic [6:0] k;
		e = '0;
		k = cap_of(r.cls);
		if (r.valid && en) begin
			e.valid = 1'b1;
			e.known = k[6];
			e.cap = k[5:0];
			e.permitted = r.raised & k[5:0];
			e.denied = |(r.raised & ~k[5:0]);
		end
		return e;
	endfunction

	// reference pipeline: answer lands one edge after the taking edge
	always @(posedge clk) begin
		if (!rst_n) begin
			s1 <= '0;
			s2 <= '0;
		end else begin
			s1 <= exp_rsp(look_req, en_exp);
			s2 <= s1;
			c1 <= look_req.cls;
			c2 <= c1;
		end
	end

	always @(negedge clk) begin
		if (rst_n) begin
			`CHK(look_rsp, s2, "lookup response")
			if (s2.denied) begin
				exp_vcnt++;
				exp_cls = c2;
			end
		end
	end

	task automatic do_reset();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		en_exp = 1'b1;
		exp_vcnt = 0;
		exp_cls = '0;
	endtask

	// answer taken at the very edge that samples pready high, then released
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
			input logic [31:0] expd, input logic experr);
		int n;
		logic [31:0] rd;
		logic err;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		penable <= 1'b0;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t no pready", $time);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		`CHK(err, experr, "pslverr")
		if (!wr) `CHK(rd, expd, "read data")
	endtask

	// mode 0: all flags raised, 1: exactly the capability, 2: divide by zero alone
	task automatic scan(input logic [1:0] mode);
		logic [6:0] k;
		for (int i = 0; i < 64; i++) begin
			k = cap_of(6'(i));
			@(posedge clk);
			look_req.valid <= 1'b1;
			look_req.cls <= 6'(i);
			look_req.raised <= (mode == 2'h0) ? 6'h3F : (mode == 2'h1) ? k[5:0] : 6'h08;
		end
		@(posedge clk);
		look_req <= '0;
		repeat (4) @(posedge clk);
	endtask

	task automatic t_regs();
		xfer(1'b0, VFEM_CTRL_OFF, '0, 32'h0000_0001, 1'b0);
		xfer(1'b0, VFEM_STATUS_OFF, '0, 32'h0000_0000, 1'b0);
		xfer(1'b0, VFEM_QUERY_OFF, '0, 32'h0000_0000, 1'b0);
		xfer(1'b0, VFEM_VCOUNT_OFF, '0, 32'h0000_0000, 1'b0);
		xfer(1'b0, 12'h010, '0, 32'h0000_0000, 1'b1);
		xfer(1'b1, 12'h010, 32'hFFFF_FFFF, '0, 1'b1);
		xfer(1'b0, VFEM_CTRL_OFF, '0, 32'h0000_0001, 1'b0);
	endtask

	task automatic t_scan();
		scan(2'h0);
		xfer(1'b0, VFEM_VCOUNT_OFF, '0, 32'(exp_vcnt), 1'b0);
		xfer(1'b0, VFEM_STATUS_OFF, '0, (32'(exp_cls) << 8) | 32'h1, 1'b0);
		xfer(1'b1, VFEM_STATUS_OFF, 32'h0000_0001, '0, 1'b0);
		xfer(1'b0, VFEM_STATUS_OFF, '0, 32'(exp_cls) << 8, 1'b0);
		scan(2'h1);
		scan(2'h2);
		xfer(1'b0, VFEM_VCOUNT_OFF, '0, 32'(exp_vcnt), 1'b0);
	endtask

	// ro and unused bits written as ones must not stick
	task automatic t_query();
		logic [6:0] k;
		for (int c = 0; c < 64; c++) begin
			k = cap_of(6'(c));
			xfer(1'b1, VFEM_QUERY_OFF, 32'hFFFF_FFC0 | 32'(c), '0, 1'b0);
			xfer(1'b0, VFEM_QUERY_OFF, '0, {~k[6], 9'h000, k[5:0], 10'h000, 6'(c)}, 1'b0);
		end
	endtask

	task automatic t_disable();
		xfer(1'b1, VFEM_CTRL_OFF, 32'hFFFF_FFFE, '0, 1'b0);
		en_exp = 1'b0;
		xfer(1'b0, VFEM_CTRL_OFF, '0, 32'h0000_0000, 1'b0);
		scan(2'h0);
		xfer(1'b0, VFEM_VCOUNT_OFF, '0, 32'(exp_vcnt), 1'b0);
		xfer(1'b1, VFEM_CTRL_OFF, 32'h0000_0001, '0, 1'b0);
		en_exp = 1'b1;
		scan(2'h0);
	endtask

	task automatic t_rereset();
		do_reset();
		xfer(1'b0, VFEM_VCOUNT_OFF, '0, 32'h0000_0000, 1'b0);
		xfer(1'b0, VFEM_STATUS_OFF, '0, 32'h0000_0000, 1'b0);
		xfer(1'b0, VFEM_CTRL_OFF, '0, 32'h0000_0001, 1'b0);
		scan(2'h2);
	endtask

	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// whole run is about a thousand cycles; this leaves a wide margin
	initial begin
		#100us;
		error_cnt++;
		$display("CHECK FAILED t=%0t watchdog expired", $time);
		complete_run();
	end

	initial begin
		do_reset();
		t_regs();
		t_scan();
		t_query();
		t_disable();
		t_rereset();
		complete_run();
	end
endmodule
